// ### logic/lcch_top.sv
// Link-configuration command handler: register front end and decoder.
// Assumes the packet layer has stripped header and checksum, and that
// host-driver writes arrive on the same clock; driver status is a pin.
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "lcch_defines.svh"
module lcch_top (
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	input  wire logic [4:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	input  wire logic                host_drv_up,
	input  wire logic                host_wr_valid,
	input  wire logic [31:0]         host_wr_settings,
	output lcch_pkg::lcch_link_t     link_o,
	output logic                     resp_pulse
);
	// Bus answer flops
	logic                    wait_ff;      // Waitrequest, high when idle
	logic [31:0]             rdata_ff;     // Registered read data
	// Software-visible command registers
	logic [7:0]              cmd_ff;       // Command code
	logic [31:0]             link_ff;      // Requested settings word
	logic [31:0]             vend_ff;      // Requested vendor word
	logic                    go_ff;        // Start request, self-clearing
	// Response registers
	logic [15:0]             rc_ff;        // Response code
	logic [15:0]             rsn_ff;       // Reason code
	logic                    done_ff;      // Sticky response-ready flag
	logic                    resp_ff;      // One-cycle response pulse
	// Driver status synchroniser
	logic                    host_s1_ff;   // First stage, feeds second only
	logic                    host_ff;      // Usable driver-up level
	// Sequencer
	lcch_pkg::lcch_state_t   state_ff;     // Current state
	lcch_pkg::lcch_state_t   nxt_state;    // Next state
	lcch_pkg::lcch_link_t    link_out_ff;  // Output to link control
	// Decode results
	logic                    acc;          // Bus access accepted this edge
	logic                    wr_acc;       // Write accepted
	logic                    start;        // Command launches
	logic                    done_clr;     // Software clears done flag
	logic [31:0]             wmask;        // Byte-lane mask
	logic                    an;           // Auto-negotiation requested
	logic [6:0]              spd;          // Requested speeds
	logic [1:0]              dup;          // Requested duplex modes
	logic                    spd_one;      // Exactly one speed, supported
	logic                    dup_one;      // Exactly one duplex, supported
	logic                    ok_cfg;       // Parameters acceptable
	logic [31:0]             nxt_word;     // Word to apply
	logic [15:0]             nxt_rc;       // Response code to report
	logic [15:0]             nxt_rsn;      // Reason to report
	logic                    nxt_apply;    // Drive the link this time

	// Avalon answer: every access waits one cycle, then completes
	assign acc      = (avs_read | avs_write) & ~wait_ff;
	assign wr_acc   = avs_write & ~wait_ff;
	assign wmask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign start    = go_ff & state_ff[0];
	assign done_clr = wr_acc & (avs_address == `LCCH_OFS_FLAGS)
		& avs_byteenable[0] & avs_writedata[0];

	// Waitrequest: low for exactly one cycle per request
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wait_ff <= 1'b1;
		end else if ((avs_read | avs_write) & wait_ff) begin
			wait_ff <= 1'b0;
		end else begin
			wait_ff <= 1'b1;
		end
	end

	// Read data, loaded as waitrequest falls; unmapped reads zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read & wait_ff) begin
			case (avs_address)
				`LCCH_OFS_CTRL:     rdata_ff <= {23'h0, go_ff, cmd_ff};
				`LCCH_OFS_LINK:     rdata_ff <= link_ff;
				`LCCH_OFS_VENDOR:   rdata_ff <= vend_ff;
				`LCCH_OFS_RESP:     rdata_ff <= {rc_ff, rsn_ff};
				`LCCH_OFS_FLAGS:    rdata_ff <= {29'h0, host_ff, ~state_ff[0], done_ff};
				`LCCH_OFS_APPLIED:  rdata_ff <= link_out_ff.settings;
				`LCCH_OFS_APP_VEND: rdata_ff <= link_out_ff.vendor;
				default:            rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// Command words, byte-lane writes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cmd_ff  <= 8'h00;
			link_ff <= `LCCH_RST_WORD;
			vend_ff <= `LCCH_RST_WORD;
		end else if (wr_acc) begin
			if (avs_address == `LCCH_OFS_CTRL && avs_byteenable[0]) begin
				cmd_ff <= avs_writedata[7:0];
			end
			// Settings and vendor words keep their packet order
			if (avs_address == `LCCH_OFS_LINK) begin
				link_ff <= (link_ff & ~wmask) | (avs_writedata & wmask);
			end
			if (avs_address == `LCCH_OFS_VENDOR) begin
				vend_ff <= (vend_ff & ~wmask) | (avs_writedata & wmask);
			end
		end
	end

	// Go bit: a write while busy is dropped, so one command at a time
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			go_ff <= 1'b0;
		end else if (start) begin
			go_ff <= 1'b0;
		end else if (wr_acc && avs_address == `LCCH_OFS_CTRL && avs_byteenable[1]
			&& state_ff[0]) begin
			go_ff <= avs_writedata[`LCCH_CTRL_GO];
		end
	end

	// Driver status crosses in through two flops
	// Costs two cycles of lag; driver changes are slow anyway
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			host_s1_ff <= 1'b0;
			host_ff    <= 1'b0;
		end else begin
			host_s1_ff <= host_drv_up;
			host_ff    <= host_s1_ff;
		end
	end

	// Field split of the requested word
	assign an  = link_ff[`LCCH_BIT_AN];
	assign spd = link_ff[`LCCH_SPD_HI:`LCCH_SPD_LO];
	assign dup = link_ff[`LCCH_DUP_HI:`LCCH_DUP_LO];
	// Forced mode wants one bit, and one the PHY can do
	assign spd_one = (spd != 7'h00) && ((spd & (spd - 7'h01)) == 7'h00)
		&& ((spd & ~`LCCH_SUP_SPEED) == 7'h00);
	assign dup_one = (dup != 2'h0) && (dup != 2'h3)
		&& ((dup & ~`LCCH_SUP_DUPLEX) == 2'h0);
	// Negotiation accepts anything; masking happens at apply
	assign ok_cfg  = an | (spd_one & dup_one);

	// Verdict on the pending command
	always_comb begin
		nxt_word  = link_ff;
		nxt_rc    = `LCCH_RC_OK;
		nxt_rsn   = `LCCH_RSN_NONE;
		nxt_apply = 1'b0;
		if (cmd_ff != `LCCH_CMD_SET_LINK) begin
			// Other commands belong elsewhere; still answered
			nxt_rc  = `LCCH_RC_FAIL;
			nxt_rsn = `LCCH_RSN_BAD_CMD;
		end else if (host_ff) begin
			// Driver owns the link; leave it alone
			nxt_rsn = `LCCH_RSN_HOST;
		end else if (!ok_cfg) begin
			// Zero, several or unsupported bits: nothing to force
			nxt_rc  = `LCCH_RC_FAIL;
			nxt_rsn = `LCCH_RSN_INVALID;
		end else begin
			// Advertise every requested speed and duplex the PHY supports; drop others
			nxt_word[`LCCH_SPD_HI:`LCCH_SPD_LO] = spd & `LCCH_SUP_SPEED;
			nxt_word[`LCCH_DUP_HI:`LCCH_DUP_LO] = dup & `LCCH_SUP_DUPLEX;
			nxt_apply = 1'b1;
		end
	end

	// Sequencer: check in one cycle, respond in the next
	always_comb begin
		case (state_ff)
			lcch_pkg::LCCH_IDLE:  nxt_state = start ? lcch_pkg::LCCH_CHECK
				: lcch_pkg::LCCH_IDLE;
			lcch_pkg::LCCH_CHECK: nxt_state = lcch_pkg::LCCH_DONE;
			lcch_pkg::LCCH_DONE:  nxt_state = lcch_pkg::LCCH_IDLE;
			default:              nxt_state = lcch_pkg::LCCH_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_ff <= lcch_pkg::LCCH_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Response capture; the link itself may settle much later
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rc_ff   <= `LCCH_RC_OK;
			rsn_ff  <= `LCCH_RSN_NONE;
			resp_ff <= 1'b0;
		end else begin
			resp_ff <= state_ff[1];
			if (state_ff[1]) begin
				rc_ff  <= nxt_rc;
				rsn_ff <= nxt_rsn;
			end
		end
	end

	// Done flag: a new response beats a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= state_ff[1] | (done_ff & ~done_clr);
		end
	end

	// Applied settings: host writes win, nothing restored on driver loss
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			link_out_ff <= '0;
		end else begin
			link_out_ff.apply <= 1'b0;
			if (host_wr_valid) begin
				link_out_ff.settings     <= host_wr_settings;
				// Driver word carries no vendor part; drop ours
				link_out_ff.vendor       <= `LCCH_RST_WORD;
				link_out_ff.vendor_valid <= 1'b0;
				link_out_ff.pause_en     <= ~host_wr_settings[`LCCH_BIT_PAUSE_N];
				link_out_ff.asym_en      <= host_wr_settings[`LCCH_BIT_ASYM];
				link_out_ff.apply        <= 1'b1;
			end else if (state_ff[1] && nxt_apply) begin
				link_out_ff.settings     <= nxt_word;
				// Pause bit is inverted: one switches pause off
				link_out_ff.pause_en     <= ~link_ff[`LCCH_BIT_PAUSE_N];
				link_out_ff.asym_en      <= link_ff[`LCCH_BIT_ASYM];
				link_out_ff.vendor_valid <= link_ff[`LCCH_BIT_VEND_OK];
				link_out_ff.vendor       <= link_ff[`LCCH_BIT_VEND_OK] ? vend_ff
					: `LCCH_RST_WORD;
				link_out_ff.apply        <= 1'b1;
			end
		end
	end

	// Outputs straight from flops
	assign avs_readdata    = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign link_o          = link_out_ff;
	assign resp_pulse      = resp_ff;

	// Checks on the handler's own registers and outputs
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_launch;
		start ##1 state_ff[1];
	endsequence
	sequence s_answer;
		##1 resp_ff && done_ff;
	endsequence

	a_resp_bound: assert property (s_launch |-> s_answer)
		else $error("No response two cycles after launch");
	a_bad_cmd_fail: assert property (state_ff[1] && cmd_ff != `LCCH_CMD_SET_LINK
		|=> rc_ff == `LCCH_RC_FAIL)
		else $error("Unknown command not failed");
	a_host_conflict: assert property (state_ff[1] && host_ff
		&& cmd_ff == `LCCH_CMD_SET_LINK && !host_wr_valid
		|=> rsn_ff == `LCCH_RSN_HOST && $stable(link_out_ff.settings))
		else $error("Conflict not reported or link changed");
	a_forced_multi: assert property (state_ff[1] && !an && !host_ff
		&& cmd_ff == `LCCH_CMD_SET_LINK && (spd & (spd - 7'h01)) != 7'h00
		|=> rc_ff == `LCCH_RC_FAIL && rsn_ff == `LCCH_RSN_INVALID)
		else $error("Forced multi-speed not rejected");
	a_forced_duplex: assert property (state_ff[1] && !an && !host_ff
		&& cmd_ff == `LCCH_CMD_SET_LINK && dup == 2'h3
		|=> rc_ff == `LCCH_RC_FAIL)
		else $error("Forced dual duplex not rejected");
	a_an_advertise: assert property (state_ff[1] && an && !host_ff
		&& cmd_ff == `LCCH_CMD_SET_LINK && !host_wr_valid
		|=> link_out_ff.settings[7:1] == ($past(spd) & `LCCH_SUP_SPEED)
		&& link_out_ff.apply)
		else $error("Negotiated speeds not advertised");
	a_vendor_gate: assert property (link_out_ff.apply && !link_out_ff.vendor_valid
		|-> link_out_ff.vendor == `LCCH_RST_WORD)
		else $error("Vendor word used while invalid");
	a_pause_polar: assert property (link_out_ff.apply
		|-> link_out_ff.pause_en != link_out_ff.settings[`LCCH_BIT_PAUSE_N])
		else $error("Pause polarity wrong");
	a_host_wins: assert property (host_wr_valid
		|=> link_out_ff.settings == $past(host_wr_settings))
		else $error("Host settings not taken");
	a_hold_word: assert property (!host_wr_valid && !state_ff[1]
		|=> $stable(link_out_ff.settings))
		else $error("Applied word changed unprompted");
	a_bus_ack: assert property ((avs_read || avs_write) && wait_ff
		|=> !wait_ff ##1 wait_ff)
		else $error("Waitrequest not one-cycle low");

	// Bus side: idle cycles leave the port waiting, read data parked
	// Without this a stray low waitrequest would ack a phantom access
	a_wait_idle: assert property (!avs_read && !avs_write |=> wait_ff)
		else $error("Waitrequest low without a request");
	// Masters may sample late; the word must not drift meanwhile
	a_rdata_stable: assert property (!(avs_read && wait_ff) |=> $stable(rdata_ff))
		else $error("Read data changed outside a read");

	// Synchroniser keeps its order: second flop copies the first
	a_sync_order: assert property (host_ff == $past(host_s1_ff))
		else $error("Driver status skipped a synchroniser stage");
	// Go only lives while idle; a busy write must not queue a command
	a_go_when_idle: assert property (!state_ff[0] |-> !go_ff)
		else $error("Go bit set while busy");

	// Response side: one pulse per command, done flag cleared on request
	a_resp_once: assert property (resp_ff |=> !resp_ff)
		else $error("Response pulse longer than one cycle");
	a_done_clear: assert property (done_ff && done_clr && !state_ff[1] |=> !done_ff)
		else $error("Done flag not cleared");

	// Link side: a forced, supported request lands unchanged
	sequence s_forced_ok;
		state_ff[1] && !an && !host_ff && spd_one && dup_one
			&& cmd_ff == `LCCH_CMD_SET_LINK && !host_wr_valid;
	endsequence
	sequence s_applied;
		link_out_ff.apply && link_out_ff.settings == $past(link_ff);
	endsequence
	a_forced_apply: assert property (s_forced_ok |=> s_applied)
		else $error("Forced settings not applied");
	// Foreign commands still get an answer, but never touch the link
	a_bad_cmd_keep: assert property (state_ff[1] && cmd_ff != `LCCH_CMD_SET_LINK
		&& !host_wr_valid |=> !link_out_ff.apply && $stable(link_out_ff.settings))
		else $error("Unknown command changed the link");
	// Apply is a strobe: link control must not see it twice
	a_apply_once: assert property (link_out_ff.apply && !host_wr_valid && !state_ff[1]
		|=> !link_out_ff.apply)
		else $error("Apply pulse longer than one cycle");
endmodule : lcch_top
`default_nettype wire

// ### pkg/lcch_defines.svh
// Constants for the link-configuration command handler.
// Assumes byte addresses on a 32-bit Avalon-MM slave port.
// How it works
// - Command code 0x09 means link reconfigure
// - Settings word, then vendor word, then checksum
// - Host driver down: apply commanded link setup
// - Apply even when current link drops
// - Respond promptly; link change may lag
// - Keep commanded settings until host overwrites
// - Operational host driver settings take precedence
// - Driver going down restores nothing
// - Bit 0 enables auto-negotiation
// - Bits 1-7 enable speeds, 10M up to 40G
// - Auto-negotiation advertises every requested speed
// - Forced mode: one supported speed, else fail
// - Bit 8 half duplex, bit 9 full
// - Forced mode: bad duplex request fails
// - Bit 10 set disables symmetric pause
// - Bit 11 enables asymmetric pause
// - Bit 12 validates the vendor word
// - Always accept and answer the command
// - Driver operational: no change, conflict reason
// - Auto-negotiation silently drops unsupported bits
`ifndef LCCH_DEFINES_SVH
`define LCCH_DEFINES_SVH
// Register byte offsets
`define LCCH_OFS_CTRL     5'h00
`define LCCH_OFS_LINK     5'h04
`define LCCH_OFS_VENDOR   5'h08
`define LCCH_OFS_RESP     5'h0C
`define LCCH_OFS_FLAGS    5'h10
`define LCCH_OFS_APPLIED  5'h14
`define LCCH_OFS_APP_VEND 5'h18
// Field positions
`define LCCH_CTRL_GO      8
`define LCCH_BIT_AN       0
`define LCCH_SPD_LO       1
`define LCCH_SPD_HI       7
`define LCCH_DUP_LO       8
`define LCCH_DUP_HI       9
`define LCCH_BIT_PAUSE_N  10
`define LCCH_BIT_ASYM     11
`define LCCH_BIT_VEND_OK  12
// Codes
`define LCCH_CMD_SET_LINK 8'h09
`define LCCH_RC_OK        16'h0000
`define LCCH_RC_FAIL      16'h0001
`define LCCH_RSN_NONE     16'h0000
`define LCCH_RSN_BAD_CMD  16'h0001
`define LCCH_RSN_INVALID  16'h0002
`define LCCH_RSN_HOST     16'h0901
// Capability of the attached PHY: speeds 10M..10G, both duplexes
`define LCCH_SUP_SPEED    7'h0F
`define LCCH_SUP_DUPLEX   2'h3
// Reset values
`define LCCH_RST_WORD     32'h0000_0000
`endif

// ### pkg/lcch_pkg.sv
// Types for the link-configuration command handler.
// Assumes lcch_defines.svh carries all numeric constants.
package lcch_pkg;
	// Settings handed to the link control logic
	typedef struct packed {
		logic [31:0] settings;     // Applied link settings word
		logic [31:0] vendor;       // Applied vendor word, zero if invalid
		logic        vendor_valid; // Vendor word in use
		logic        pause_en;     // Symmetric pause enabled
		logic        asym_en;      // Asymmetric pause enabled
		logic        apply;        // One-cycle pulse: reconfigure link now
	} lcch_link_t;
	// Command sequencer states, one-hot
	typedef enum logic [2:0] {
		LCCH_IDLE  = 3'b001,
		LCCH_CHECK = 3'b010,
		LCCH_DONE  = 3'b100
	} lcch_state_t;
endpackage : lcch_pkg

// ### testbench/lcch_mc_model.sv
// Management controller model: an Avalon-MM master that issues commands.
// Assumes the handler's clock and its waitrequest handshake.
`timescale 1ns/100ps
`default_nettype none
module lcch_mc_model (
	input  wire logic        clk_sys,
	input  wire logic        avs_waitrequest,
	input  wire logic [31:0] avs_readdata,
	output logic      [4:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable,
	output logic             hang_ff
);
	// Idle bus at time zero
	initial begin
		avs_address = 5'h00;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		hang_ff = 1'h0;
	end
	// One access; request held until waitrequest is seen low, for at most 32 cycles
	task automatic access(input logic [4:0] a, input logic wr, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 32);
		// A slave that never answers is flagged, not waited on forever
		if (avs_waitrequest !== 1'h0) begin
			hang_ff = 1'h1;
		end
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		// Released data lines must not keep showing the old word
		avs_writedata <= ~d;
	endtask : access
endmodule : lcch_mc_model
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the link-configuration command handler.
// Assumes the management controller model drives the register bus.
`timescale 1ns/100ps
`default_nettype none
`include "lcch_defines.svh"
module tb_top;
	logic                 clk_sys = 1'h0;          // 20 MHz
	logic                 rst_n = 1'h0;            // Sync, active low
	logic                 host_drv_up;             // Driver status pin
	logic                 host_wr_valid;           // Host write strobe
	logic [31:0]          host_wr_settings;        // Host settings word
	wire  [4:0]           avs_address;
	wire                  avs_read;
	wire                  avs_write;
	wire  [31:0]          avs_writedata;
	wire  [3:0]           avs_byteenable;
	wire  [31:0]          avs_readdata;
	wire                  avs_waitrequest;
	wire                  resp_pulse;
	wire                  hang;
	lcch_pkg::lcch_link_t link_o;
	logic [31:0]          exp_app = 32'h0000_0000; // Expected applied word
	logic [31:0]          exp_ven = 32'h0000_0000; // Expected vendor word
	logic                 exp_pau = 1'h0;          // Expected pause flag; reset leaves it off
	logic [31:0]          corner [6] = '{32'h0000_02F3, 32'h0000_0206, 32'h0000_0240,
		32'h0000_0304, 32'h0000_1D08, 32'h0000_0210};
	int                   fail_count = 0;
	int                   compares = 0;
	// Clock
	always #25 clk_sys = ~clk_sys;
	lcch_mc_model i_mc (.clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .hang_ff(hang));
	lcch_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .host_drv_up(host_drv_up),
		.host_wr_valid(host_wr_valid), .host_wr_settings(host_wr_settings),
		.link_o(link_o), .resp_pulse(resp_pulse));
	// Verdict and end of run
	task automatic wrap_up();
		// A stuck bus counts against the run
		if (hang) begin
			fail_count++;
		end
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up
	// Single comparison point
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Response word from command code, settings and driver state
	function automatic logic [31:0] exp_resp(input logic [7:0] c, input logic [31:0] w,
		input logic up);
		if (c !== `LCCH_CMD_SET_LINK) begin
			return {`LCCH_RC_FAIL, `LCCH_RSN_BAD_CMD};
		end
		if (up) begin
			return {`LCCH_RC_OK, `LCCH_RSN_HOST};
		end
		// Forced mode needs exactly one supported speed and one duplex
		if (!w[0] && (!$onehot(w[7:1]) || (w[7:1] & ~`LCCH_SUP_SPEED) != 7'h00
			|| !$onehot(w[9:8]))) begin
			return {`LCCH_RC_FAIL, `LCCH_RSN_INVALID};
		end
		return {`LCCH_RC_OK, `LCCH_RSN_NONE};
	endfunction : exp_resp
	// Full command: settings, vendor word, then go; checks response, flags, applied word, vendor, pause and asym
	task automatic run_cmd(input logic [7:0] c, input logic [31:0] w, input logic [31:0] v);
		logic [31:0] q;
		logic [31:0] r;
		logic        ok;
		int          n;
		r = exp_resp(c, w, host_drv_up);
		ok = (r === {`LCCH_RC_OK, `LCCH_RSN_NONE});
		if (ok) begin
			// Auto-negotiation drops unsupported speeds
			exp_app = w[0] ? {w[31:8], w[7:1] & `LCCH_SUP_SPEED, w[0]} : w;
			exp_ven = w[12] ? v : 32'h0000_0000;
			exp_pau = !w[10];
		end
		i_mc.access(`LCCH_OFS_LINK, 1'h1, w, q);
		i_mc.access(`LCCH_OFS_VENDOR, 1'h1, v, q);
		i_mc.access(`LCCH_OFS_CTRL, 1'h1, {23'h00_0000, 1'h1, c}, q);
		n = 0;
		while (resp_pulse !== 1'h1 && n < 16) begin
			@(posedge clk_sys);
			n++;
		end
		chk("resp_in_time", n < 16, 32'h0000_0001);
		chk("apply", link_o.apply, ok);
		i_mc.access(`LCCH_OFS_RESP, 1'h0, 32'h0000_0000, q);
		chk("resp", q, r);
		i_mc.access(`LCCH_OFS_FLAGS, 1'h0, 32'h0000_0000, q);
		chk("flags", q, {29'h0000_0000, host_drv_up, 2'h1});
		i_mc.access(`LCCH_OFS_FLAGS, 1'h1, 32'h0000_0001, q);
		i_mc.access(`LCCH_OFS_FLAGS, 1'h0, 32'h0000_0000, q);
		chk("flags_clr", q, {29'h0000_0000, host_drv_up, 2'h0});
		i_mc.access(`LCCH_OFS_APPLIED, 1'h0, 32'h0000_0000, q);
		chk("applied_reg", q, exp_app);
		chk("link_settings", link_o.settings, exp_app);
		chk("link_vendor", link_o.vendor, exp_ven);
		chk("pause", link_o.pause_en, exp_pau);
		chk("asym", link_o.asym_en, exp_app[11]);
		if (hang || n >= 16) begin
			wrap_up();
		end
	endtask : run_cmd
	// Main sequence
	initial begin
		logic [31:0] q;
		host_drv_up = 1'h0;
		host_wr_valid = 1'h0;
		host_wr_settings = 32'h0000_0000;
		void'($urandom(32'h42ef));
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'h1;
		chk("link_rst", link_o.settings, 32'h0000_0000);
		i_mc.access(5'h1C, 1'h0, 32'h0000_0000, q);
		chk("unmapped", q, 32'h0000_0000);
		// Random settings, driver down
		repeat (12) run_cmd(`LCCH_CMD_SET_LINK, $urandom & 32'h0000_1FFF, $urandom);
		$display("test random done");
		// Boundary settings and an unknown command code
		foreach (corner[i]) run_cmd(`LCCH_CMD_SET_LINK, corner[i], 32'hA5A5_5A5A);
		run_cmd(8'h3C, 32'h0000_0209, 32'h0000_0000);
		$display("test corners done");
		// Driver up: command refused, host write wins
		host_drv_up <= 1'h1;
		repeat (4) @(posedge clk_sys);
		run_cmd(`LCCH_CMD_SET_LINK, 32'h0000_0305, 32'h0000_0000);
		host_wr_valid <= 1'h1;
		host_wr_settings <= 32'h0000_0209;
		@(posedge clk_sys);
		host_wr_valid <= 1'h0;
		@(posedge clk_sys);
		chk("host_word", link_o.settings, 32'h0000_0209);
		chk("host_vendor", link_o.vendor, 32'h0000_0000);
		exp_app = 32'h0000_0209;
		exp_ven = 32'h0000_0000;
		exp_pau = 1'h1;
		// Driver down again: nothing restored
		host_drv_up <= 1'h0;
		repeat (4) @(posedge clk_sys);
		chk("kept_word", link_o.settings, 32'h0000_0209);
		run_cmd(`LCCH_CMD_SET_LINK, 32'h0000_1209, 32'h1234_5678);
		$display("test host path done");
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
